// *** ppc_pkg.sv ***
// package: register addresses, reset values and field masks of the port pad configuration block
package ppc_pkg;
	localparam int PPC_NUM_REGS = 9;
	localparam logic [7:0] PPC_ADDR_PU0 = 8'ha4;
	localparam logic [7:0] PPC_ADDR_PU1 = 8'ha5;
	localparam logic [7:0] PPC_ADDR_PU2 = 8'ha6;
	localparam logic [7:0] PPC_ADDR_PU3 = 8'ha7;
	localparam logic [7:0] PPC_ADDR_PU4 = 8'hac;
	localparam logic [7:0] PPC_ADDR_PU5 = 8'had;
	localparam logic [7:0] PPC_ADDR_PU6 = 8'hae;
	localparam logic [7:0] PPC_ADDR_PU7 = 8'haf;
	localparam logic [7:0] PPC_ADDR_DIR7 = 8'hbf;
	// reset: pull-ups off, port 7 in output mode
	localparam logic [7:0] PPC_RST_PU = 8'h00;
	localparam logic [7:0] PPC_RST_DIR7 = 8'h00;
	// implemented bits per register, indexed like the address table
	localparam logic [7:0] PPC_MASK_FULL = 8'hff;
	localparam logic [7:0] PPC_MASK_PU2 = 8'hf0;
	localparam logic [7:0] PPC_MASK_PU3 = 8'h3f;
	typedef logic [7:0] ppc_byte_t;
	typedef ppc_byte_t [PPC_NUM_REGS-1:0] ppc_bank_t;
	localparam ppc_bank_t PPC_ADDR_TABLE = '{PPC_ADDR_DIR7, PPC_ADDR_PU7, PPC_ADDR_PU6,
		PPC_ADDR_PU5, PPC_ADDR_PU4, PPC_ADDR_PU3, PPC_ADDR_PU2, PPC_ADDR_PU1, PPC_ADDR_PU0};
	localparam ppc_bank_t PPC_MASK_TABLE = '{PPC_MASK_FULL, PPC_MASK_FULL, PPC_MASK_FULL,
		PPC_MASK_FULL, PPC_MASK_FULL, PPC_MASK_PU3, PPC_MASK_PU2, PPC_MASK_FULL, PPC_MASK_FULL};
	localparam ppc_bank_t PPC_RST_TABLE = '{PPC_RST_DIR7, PPC_RST_PU, PPC_RST_PU, PPC_RST_PU,
		PPC_RST_PU, PPC_RST_PU, PPC_RST_PU, PPC_RST_PU, PPC_RST_PU};
	localparam int PPC_IDX_DIR7 = 8;
endpackage : ppc_pkg

// *** ppc_bank_if.sv ***
// interface between the access decoder and the register bank
interface ppc_bank_if;
	import ppc_pkg::*;
	logic [PPC_NUM_REGS-1:0] writeSel;
	ppc_byte_t writeData;
	ppc_bank_t bankValue;
	modport ctrl (output writeSel, output writeData, input bankValue);
	modport bank (input writeSel, input writeData, output bankValue);
endinterface : ppc_bank_if

// *** ppc_reg_bank.sv ***
// register bank: nine byte-wide configuration registers with masked bits
module ppc_reg_bank
	import ppc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	ppc_bank_if.bank bus
);
	typedef struct packed {
		ppc_bank_t regs;
	} ppc_bank_s;
	ppc_bank_s state;
	ppc_bank_s next_state;

	// whole-byte write; unimplemented bits forced to zero so they never hold a value
	always_comb begin
		next_state = state;
		for (int i = 0; i < PPC_NUM_REGS; i++) begin
			if (bus.writeSel[i]) begin
				next_state.regs[i] = bus.writeData & PPC_MASK_TABLE[i];
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state.regs <= PPC_RST_TABLE;
		end else begin
			state <= next_state;
		end
	end

	assign bus.bankValue = state.regs;

	// a masked bit must never read back as one
	AST_MASKED_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state.regs[2][3:0] == 4'h0) && (state.regs[3][7:6] == 2'h0))
		else $error("unimplemented bits hold a one");
endmodule : ppc_reg_bank

// *** ppc_port_pad_config.sv ***
// top: special-function-register access and pad control outputs for port pull-ups and port 7 direction
module ppc_port_pad_config
	import ppc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWrite,
	input wire logic sfrRead,
	input wire logic [7:0] sfrWriteData,
	output logic [7:0] sfrReadData,
	output logic sfrHit,
	output logic [7:0] port0PullupOn,
	output logic [7:0] port1PullupOn,
	output logic [3:0] port2PullupOn,
	output logic [5:0] port3PullupOn,
	output logic [7:0] port4PullupOn,
	output logic [7:0] port5PullupOn,
	output logic [7:0] port6PullupOn,
	output logic [7:0] port7PullupOn,
	output logic [7:0] port7PinInputSelect
);
	ppc_bank_if bankBus();

	typedef struct packed {
		logic [7:0] readData;
		logic hit;
		logic [7:0] pu0;
		logic [7:0] pu1;
		logic [3:0] pu2;
		logic [5:0] pu3;
		logic [7:0] pu4;
		logic [7:0] pu5;
		logic [7:0] pu6;
		logic [7:0] pu7;
		logic [7:0] dir7;
	} ppc_top_s;
	ppc_top_s state;
	ppc_top_s next_state;
	logic [PPC_NUM_REGS-1:0] addrMatch;

	// one address comparator per register; the core only issues byte addresses
	genvar g;
	generate
		for (g = 0; g < PPC_NUM_REGS; g++) begin : gDecode
			assign addrMatch[g] = (sfrAddr == PPC_ADDR_TABLE[g]);
		end
	endgenerate

	// write strobe reaches the bank only for a decoded address, as a full byte
	assign bankBus.writeSel = sfrWrite ? addrMatch : '0;
	assign bankBus.writeData = sfrWriteData;

	ppc_reg_bank uBank (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.bus(bankBus.bank)
	);

	// pad controls follow the bank one cycle late so every output leaves a flop
	always_comb begin
		next_state = state;
		next_state.pu0 = bankBus.bankValue[0];
		next_state.pu1 = bankBus.bankValue[1];
		next_state.pu2 = bankBus.bankValue[2][7:4];
		next_state.pu3 = bankBus.bankValue[3][5:0];
		next_state.pu4 = bankBus.bankValue[4];
		next_state.pu5 = bankBus.bankValue[5];
		next_state.pu6 = bankBus.bankValue[6];
		next_state.pu7 = bankBus.bankValue[7];
		next_state.dir7 = bankBus.bankValue[PPC_IDX_DIR7];
		// read mux: unmapped addresses return zero and no hit
		next_state.hit = sfrRead && (|addrMatch);
		next_state.readData = 8'h00;
		if (sfrRead) begin
			for (int i = 0; i < PPC_NUM_REGS; i++) begin
				if (addrMatch[i]) begin
					next_state.readData = bankBus.bankValue[i];
				end
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= '{readData: 8'h00, hit: 1'b0, pu0: PPC_RST_PU, pu1: PPC_RST_PU,
				pu2: PPC_RST_PU[7:4], pu3: PPC_RST_PU[5:0], pu4: PPC_RST_PU, pu5: PPC_RST_PU,
				pu6: PPC_RST_PU, pu7: PPC_RST_PU, dir7: PPC_RST_DIR7};
		end else begin
			state <= next_state;
		end
	end

	assign sfrReadData = state.readData;
	assign sfrHit = state.hit;
	assign port0PullupOn = state.pu0;
	assign port1PullupOn = state.pu1;
	assign port2PullupOn = state.pu2;
	assign port3PullupOn = state.pu3;
	assign port4PullupOn = state.pu4;
	assign port5PullupOn = state.pu5;
	assign port6PullupOn = state.pu6;
	assign port7PullupOn = state.pu7;
	assign port7PinInputSelect = state.dir7;

	AST_DIR7_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == PPC_ADDR_DIR7) |-> ##2 (port7PinInputSelect == $past(sfrWriteData, 2)))
		else $error("port 7 direction did not follow write");
	AST_PU0_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == 8'ha4) |-> ##2 (port0PullupOn == $past(sfrWriteData, 2)))
		else $error("port 0 pull-up did not follow write");
	AST_PU1_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == 8'ha5) |-> ##2 (port1PullupOn == $past(sfrWriteData, 2)))
		else $error("port 1 pull-up did not follow write");
	AST_PU2_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == 8'ha6) |-> ##2 (port2PullupOn == $past(sfrWriteData[7:4], 2)))
		else $error("port 2 pull-up upper bits wrong");
	AST_PU2_LOWREAD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrRead && sfrAddr == 8'ha6) |=> (sfrReadData[3:0] == 4'h0 && sfrHit))
		else $error("port 2 low bits read nonzero");
	AST_PU3_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == 8'ha7) |-> ##2 (port3PullupOn == $past(sfrWriteData[5:0], 2)))
		else $error("port 3 pull-up wrong");
	AST_PU3_RESREAD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrRead && sfrAddr == 8'ha7) |=> (sfrReadData[7:6] == 2'h0))
		else $error("port 3 reserved bits read nonzero");
	AST_PU4_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == 8'hac) |-> ##2 (port4PullupOn == $past(sfrWriteData, 2)))
		else $error("port 4 pull-up did not follow write");
	AST_PU5_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == 8'had) |-> ##2 (port5PullupOn == $past(sfrWriteData, 2)))
		else $error("port 5 pull-up did not follow write");
	AST_PU6_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == 8'hae) |-> ##2 (port6PullupOn == $past(sfrWriteData, 2)))
		else $error("port 6 pull-up did not follow write");
	AST_PU7_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == 8'haf) |-> ##2 (port7PullupOn == $past(sfrWriteData, 2)))
		else $error("port 7 pull-up did not follow write");
	AST_UNMAPPED: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrRead && !(|addrMatch)) |=> (!sfrHit && sfrReadData == 8'h00))
		else $error("unmapped read answered");
	AST_READBACK: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == 8'hbf) ##1 (sfrRead && !sfrWrite && sfrAddr == 8'hbf)
		|=> (sfrReadData == $past(sfrWriteData, 2)))
		else $error("port 7 direction readback wrong");

	// port 0: pad holds unless written, read hits, readback new and old values, pad agrees with read
	AST_PU0_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!(sfrWrite && sfrAddr == PPC_ADDR_PU0)
		|-> ##2 $stable(port0PullupOn))
		else $error("port 0 pull-up moved without a write");
	AST_PU0_HIT: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrRead && sfrAddr == PPC_ADDR_PU0)
		|=> sfrHit)
		else $error("port 0 pull-up read not answered");
	AST_PU0_RDBACK: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == PPC_ADDR_PU0) ##1 (sfrRead && !sfrWrite && sfrAddr == PPC_ADDR_PU0)
		|=> (sfrReadData == $past(sfrWriteData & PPC_MASK_FULL, 2)))
		else $error("port 0 pull-up readback wrong");
	AST_PU0_RDOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == PPC_ADDR_PU0) ##1 (sfrRead && sfrWrite && sfrAddr == PPC_ADDR_PU0)
		|=> (sfrReadData == $past(sfrWriteData & PPC_MASK_FULL, 2)))
		else $error("port 0 pull-up read during write not old value");
	AST_PU0_PADMATCH: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrRead && sfrAddr == PPC_ADDR_PU0)
		|=> (sfrReadData == port0PullupOn))
		else $error("port 0 pad and register disagree");

	// port 1: same checks; a pad must never drift without its own write
	AST_PU1_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!(sfrWrite && sfrAddr == PPC_ADDR_PU1)
		|-> ##2 $stable(port1PullupOn))
		else $error("port 1 pull-up moved without a write");
	AST_PU1_HIT: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrRead && sfrAddr == PPC_ADDR_PU1)
		|=> sfrHit)
		else $error("port 1 pull-up read not answered");
	AST_PU1_RDBACK: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == PPC_ADDR_PU1) ##1 (sfrRead && !sfrWrite && sfrAddr == PPC_ADDR_PU1)
		|=> (sfrReadData == $past(sfrWriteData & PPC_MASK_FULL, 2)))
		else $error("port 1 pull-up readback wrong");
	AST_PU1_RDOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == PPC_ADDR_PU1) ##1 (sfrRead && sfrWrite && sfrAddr == PPC_ADDR_PU1)
		|=> (sfrReadData == $past(sfrWriteData & PPC_MASK_FULL, 2)))
		else $error("port 1 pull-up read during write not old value");
	AST_PU1_PADMATCH: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrRead && sfrAddr == PPC_ADDR_PU1)
		|=> (sfrReadData == port1PullupOn))
		else $error("port 1 pad and register disagree");

	// port 2: only the upper nibble reaches pads, the lower nibble reads zero
	AST_PU2_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!(sfrWrite && sfrAddr == PPC_ADDR_PU2)
		|-> ##2 $stable(port2PullupOn))
		else $error("port 2 pull-up moved without a write");
	AST_PU2_HIT: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrRead && sfrAddr == PPC_ADDR_PU2)
		|=> sfrHit)
		else $error("port 2 pull-up read not answered");
	AST_PU2_RDBACK: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == PPC_ADDR_PU2) ##1 (sfrRead && !sfrWrite && sfrAddr == PPC_ADDR_PU2)
		|=> (sfrReadData == $past(sfrWriteData & PPC_MASK_PU2, 2)))
		else $error("port 2 pull-up readback wrong");
	AST_PU2_RDOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == PPC_ADDR_PU2) ##1 (sfrRead && sfrWrite && sfrAddr == PPC_ADDR_PU2)
		|=> (sfrReadData == $past(sfrWriteData & PPC_MASK_PU2, 2)))
		else $error("port 2 pull-up read during write not old value");
	AST_PU2_PADMATCH: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrRead && sfrAddr == PPC_ADDR_PU2)
		|=> (sfrReadData[7:4] == port2PullupOn))
		else $error("port 2 pad and register disagree");

	// port 3: reserved top bits are dropped on write and never reach a pad
	AST_PU3_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!(sfrWrite && sfrAddr == PPC_ADDR_PU3)
		|-> ##2 $stable(port3PullupOn))
		else $error("port 3 pull-up moved without a write");
	AST_PU3_HIT: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrRead && sfrAddr == PPC_ADDR_PU3)
		|=> sfrHit)
		else $error("port 3 pull-up read not answered");
	AST_PU3_RDBACK: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == PPC_ADDR_PU3) ##1 (sfrRead && !sfrWrite && sfrAddr == PPC_ADDR_PU3)
		|=> (sfrReadData == $past(sfrWriteData & PPC_MASK_PU3, 2)))
		else $error("port 3 pull-up readback wrong");
	AST_PU3_RDOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == PPC_ADDR_PU3) ##1 (sfrRead && sfrWrite && sfrAddr == PPC_ADDR_PU3)
		|=> (sfrReadData == $past(sfrWriteData & PPC_MASK_PU3, 2)))
		else $error("port 3 pull-up read during write not old value");
	AST_PU3_PADMATCH: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrRead && sfrAddr == PPC_ADDR_PU3)
		|=> (sfrReadData[5:0] == port3PullupOn))
		else $error("port 3 pad and register disagree");

	// port 4: full byte of pull-ups
	AST_PU4_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!(sfrWrite && sfrAddr == PPC_ADDR_PU4)
		|-> ##2 $stable(port4PullupOn))
		else $error("port 4 pull-up moved without a write");
	AST_PU4_HIT: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrRead && sfrAddr == PPC_ADDR_PU4)
		|=> sfrHit)
		else $error("port 4 pull-up read not answered");
	AST_PU4_RDBACK: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == PPC_ADDR_PU4) ##1 (sfrRead && !sfrWrite && sfrAddr == PPC_ADDR_PU4)
		|=> (sfrReadData == $past(sfrWriteData & PPC_MASK_FULL, 2)))
		else $error("port 4 pull-up readback wrong");
	AST_PU4_RDOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == PPC_ADDR_PU4) ##1 (sfrRead && sfrWrite && sfrAddr == PPC_ADDR_PU4)
		|=> (sfrReadData == $past(sfrWriteData & PPC_MASK_FULL, 2)))
		else $error("port 4 pull-up read during write not old value");
	AST_PU4_PADMATCH: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrRead && sfrAddr == PPC_ADDR_PU4)
		|=> (sfrReadData == port4PullupOn))
		else $error("port 4 pad and register disagree");

	// port 5: full byte of pull-ups
	AST_PU5_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!(sfrWrite && sfrAddr == PPC_ADDR_PU5)
		|-> ##2 $stable(port5PullupOn))
		else $error("port 5 pull-up moved without a write");
	AST_PU5_HIT: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrRead && sfrAddr == PPC_ADDR_PU5)
		|=> sfrHit)
		else $error("port 5 pull-up read not answered");
	AST_PU5_RDBACK: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == PPC_ADDR_PU5) ##1 (sfrRead && !sfrWrite && sfrAddr == PPC_ADDR_PU5)
		|=> (sfrReadData == $past(sfrWriteData & PPC_MASK_FULL, 2)))
		else $error("port 5 pull-up readback wrong");
	AST_PU5_RDOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == PPC_ADDR_PU5) ##1 (sfrRead && sfrWrite && sfrAddr == PPC_ADDR_PU5)
		|=> (sfrReadData == $past(sfrWriteData & PPC_MASK_FULL, 2)))
		else $error("port 5 pull-up read during write not old value");
	AST_PU5_PADMATCH: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrRead && sfrAddr == PPC_ADDR_PU5)
		|=> (sfrReadData == port5PullupOn))
		else $error("port 5 pad and register disagree");

	// port 6: full byte of pull-ups
	AST_PU6_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!(sfrWrite && sfrAddr == PPC_ADDR_PU6)
		|-> ##2 $stable(port6PullupOn))
		else $error("port 6 pull-up moved without a write");
	AST_PU6_HIT: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrRead && sfrAddr == PPC_ADDR_PU6)
		|=> sfrHit)
		else $error("port 6 pull-up read not answered");
	AST_PU6_RDBACK: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == PPC_ADDR_PU6) ##1 (sfrRead && !sfrWrite && sfrAddr == PPC_ADDR_PU6)
		|=> (sfrReadData == $past(sfrWriteData & PPC_MASK_FULL, 2)))
		else $error("port 6 pull-up readback wrong");
	AST_PU6_RDOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == PPC_ADDR_PU6) ##1 (sfrRead && sfrWrite && sfrAddr == PPC_ADDR_PU6)
		|=> (sfrReadData == $past(sfrWriteData & PPC_MASK_FULL, 2)))
		else $error("port 6 pull-up read during write not old value");
	AST_PU6_PADMATCH: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrRead && sfrAddr == PPC_ADDR_PU6)
		|=> (sfrReadData == port6PullupOn))
		else $error("port 6 pad and register disagree");

	// port 7 pull-ups: full byte
	AST_PU7_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!(sfrWrite && sfrAddr == PPC_ADDR_PU7)
		|-> ##2 $stable(port7PullupOn))
		else $error("port 7 pull-up moved without a write");
	AST_PU7_HIT: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrRead && sfrAddr == PPC_ADDR_PU7)
		|=> sfrHit)
		else $error("port 7 pull-up read not answered");
	AST_PU7_RDBACK: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == PPC_ADDR_PU7) ##1 (sfrRead && !sfrWrite && sfrAddr == PPC_ADDR_PU7)
		|=> (sfrReadData == $past(sfrWriteData & PPC_MASK_FULL, 2)))
		else $error("port 7 pull-up readback wrong");
	AST_PU7_RDOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == PPC_ADDR_PU7) ##1 (sfrRead && sfrWrite && sfrAddr == PPC_ADDR_PU7)
		|=> (sfrReadData == $past(sfrWriteData & PPC_MASK_FULL, 2)))
		else $error("port 7 pull-up read during write not old value");
	AST_PU7_PADMATCH: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrRead && sfrAddr == PPC_ADDR_PU7)
		|=> (sfrReadData == port7PullupOn))
		else $error("port 7 pad and register disagree");

	// port 7 direction: a stray write here would flip live outputs into inputs
	AST_DIR7_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!(sfrWrite && sfrAddr == PPC_ADDR_DIR7)
		|-> ##2 $stable(port7PinInputSelect))
		else $error("port 7 direction moved without a write");
	AST_DIR7_HIT: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrRead && sfrAddr == PPC_ADDR_DIR7)
		|=> sfrHit)
		else $error("port 7 direction read not answered");
	AST_DIR7_RDOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrWrite && sfrAddr == PPC_ADDR_DIR7) ##1 (sfrRead && sfrWrite && sfrAddr == PPC_ADDR_DIR7)
		|=> (sfrReadData == $past(sfrWriteData & PPC_MASK_FULL, 2)))
		else $error("port 7 direction read during write not old value");
	AST_DIR7_PADMATCH: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sfrRead && sfrAddr == PPC_ADDR_DIR7)
		|=> (sfrReadData == port7PinInputSelect))
		else $error("port 7 direction pad and register disagree");
endmodule : ppc_port_pad_config

// *** ppc_testbench.sv ***
// self-checking bench for the port pad configuration registers
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import ppc_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] sfrAddr = 8'h00;
	logic sfrWrite = 1'b0;
	logic sfrRead = 1'b0;
	logic [7:0] sfrWriteData = 8'h00;
	logic [7:0] sfrReadData, port0PullupOn, port1PullupOn, port4PullupOn, port5PullupOn;
	logic [7:0] port6PullupOn, port7PullupOn, port7PinInputSelect;
	logic sfrHit;
	logic [3:0] port2PullupOn;
	logic [5:0] port3PullupOn;
	logic [8:0] expQ[$];
	ppc_bank_t model;
	logic readSeen = 1'b0;
	int n_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	ppc_port_pad_config ppc_port_pad_config_inst (.ref_clk, .sys_rst, .sfrAddr, .sfrWrite, .sfrRead,
		.sfrWriteData, .sfrReadData, .sfrHit, .port0PullupOn, .port1PullupOn, .port2PullupOn,
		.port3PullupOn, .port4PullupOn, .port5PullupOn, .port6PullupOn, .port7PullupOn,
		.port7PinInputSelect);
	initial begin
		forever #20 ref_clk = ~ref_clk;
	end
	task automatic chk(input string what, input logic [8:0] e, input logic [8:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// one bus cycle, entered at a falling edge; reads note the old value, so a same-cycle write is not seen
	task automatic acc(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d);
		int i;
		i = -1;
		for (int k = 0; k < PPC_NUM_REGS; k++) if (PPC_ADDR_TABLE[k] === a) i = k;
		sfrWrite = wr;
		sfrRead = rd;
		sfrAddr = a;
		sfrWriteData = d;
		if (rd) expQ.push_back(i < 0 ? 9'h000 : {1'b1, model[i]});
		if (wr && i >= 0) model[i] = d & PPC_MASK_TABLE[i];
		@(negedge ref_clk);
	endtask
	// pad outputs lag the register by one cycle, so settle idles twice first
	task automatic pads();
		chk("dir7", 9'(model[8]), 9'(port7PinInputSelect));
		chk("pu0", 9'(model[0]), 9'(port0PullupOn));
		chk("pu1", 9'(model[1]), 9'(port1PullupOn));
		chk("pu2", 9'(model[2][7:4]), 9'(port2PullupOn));
		chk("pu3", 9'(model[3][5:0]), 9'(port3PullupOn));
		chk("pu4", 9'(model[4]), 9'(port4PullupOn));
		chk("pu5", 9'(model[5]), 9'(port5PullupOn));
		chk("pu6", 9'(model[6]), 9'(port6PullupOn));
		chk("pu7", 9'(model[7]), 9'(port7PullupOn));
	endtask
	task automatic settle();
		acc(0, 0, 8'h00, 8'h00);
		acc(0, 0, 8'h00, 8'h00);
		pads();
	endtask
	// read watcher: a read edge leaves its answer standing for one cycle
	always @(posedge ref_clk) readSeen <= sfrRead & ~sys_rst;
	always @(negedge ref_clk) begin
		if (readSeen) chk("read", expQ.size() ? expQ.pop_front() : 9'h1ff, {sfrHit, sfrReadData});
	end
	// hang guard, well above the roughly 470 cycles the tests take
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles > 20000) begin
			n_errors++;
			results();
		end
	end
	initial begin
		void'($urandom(32'hdea0));
		model = PPC_RST_TABLE;
		repeat (16) @(posedge ref_clk);
		@(negedge ref_clk);
		sys_rst = 1'b0;
		for (int i = 0; i < PPC_NUM_REGS; i++) acc(0, 1, PPC_ADDR_TABLE[i], 8'h00);
		settle();
		$display("test reset values done");
		// write, read back next cycle, then write and read in one cycle; first pass all ones for the masks
		for (int p = 0; p < 4; p++) begin
			for (int i = 0; i < PPC_NUM_REGS; i++) begin
				acc(1, 0, PPC_ADDR_TABLE[i], p == 0 ? 8'hff : 8'($urandom));
				acc(0, 1, PPC_ADDR_TABLE[i], 8'h00);
				acc(1, 1, PPC_ADDR_TABLE[i], 8'($urandom));
			end
			settle();
		end
		$display("test readback and masks done");
		// unmapped neighbours must not hit or disturb any pad
		foreach (PPC_ADDR_TABLE[i]) acc(1, 1, PPC_ADDR_TABLE[i] + 8'h20, 8'hff);
		acc(1, 1, 8'ha3, 8'hff);
		settle();
		$display("test unmapped done");
		// random traffic around the register window
		repeat (300) acc(1'($urandom), 1'($urandom), 8'ha0 + 8'($urandom % 32), 8'($urandom));
		settle();
		$display("test random traffic done");
		// reset in mid-run returns every pad to its idle state
		sys_rst = 1'b1;
		model = PPC_RST_TABLE;
		@(negedge ref_clk);
		pads();
		@(negedge ref_clk);
		sys_rst = 1'b0;
		for (int i = 0; i < PPC_NUM_REGS; i++) acc(0, 1, PPC_ADDR_TABLE[i], 8'h00);
		settle();
		$display("test second reset done");
		results();
	end
endmodule // testbench
